// *** verilog/mac_pkg.sv ***
// constants shared by the multiply-accumulate datapath
// Function
// RULE1 - four-stage pipeline, 32x32 multiplier, four 48-bit accumulators
// RULE2 - first stage overlaps core's last operand stage
// RULE3 - accumulator copy after update waits three cycles
// RULE4 - load, copy, accumulate issue every cycle
// RULE5 - mode bits: 0 signed, 1/3 fractional, 2 unsigned
// RULE6 - fractional minus one is sign bit only
// RULE7 - negative is bit 47, zero when all clear
// RULE8 - sticky overflow on 40-bit product or accumulation
// RULE9 - overflow flag copies target's sticky bit
// RULE10 - saturating with sticky set leaves accumulator untouched
// RULE11 - word operands pick upper or lower halfword
// RULE12 - fractional word operand padded with sixteen zeros
// RULE13 - fractional product shifted left one bit
// RULE14 - integer product overflow saturates by sign, direction
// RULE15 - integer accumulation overflow saturates by result bit
// RULE16 - integer product sign-extended from bit 39
// RULE17 - scale factor: none, left, reserved, right
// RULE18 - right shift fill: zero or sign bit
// RULE19 - fractional mode ignores scale factor
// RULE20 - subtract variant subtracts, accumulate variant adds
// RULE21 - integer extension flag from bits 47:31
// RULE22 - fractional convergent rounding at bit 24
// RULE23 - minus one squared zero-fills top byte
// RULE24 - status: sticky 11:8, config 7:4, flags 3:0
`default_nettype none
package mac_pkg;
  // =====================================================================
  // register map (byte addresses)
  localparam logic [7:0]  STATUS_OFS   = 8'h00;
  localparam logic [7:0]  ACC_LO_OFS   = 8'h10;
  localparam logic [7:0]  ACC_HI_OFS   = 8'h20;
  localparam logic [11:0] STATUS_RESET = 12'h000;
  // =====================================================================
  // status field positions
  localparam int STICKY_LSB = 8;
  localparam int SAT_BIT    = 7;
  localparam int ROUND_BIT  = 4;
  localparam int FLAG_N     = 3;
  localparam int FLAG_Z     = 2;
  localparam int FLAG_V     = 1;
  localparam int FLAG_EV    = 0;
  // =====================================================================
  // operand modes and operations
  localparam logic [1:0] MODE_SINT = 2'h0;
  localparam logic [1:0] MODE_UINT = 2'h2;
  localparam logic [1:0] OP_MAC    = 2'h0;
  localparam logic [1:0] OP_MULTIPLY_SUBTRACT   = 2'h1;
  localparam logic [1:0] OP_LOAD   = 2'h2;
  localparam logic [1:0] OP_COPY   = 2'h3;
  localparam logic [1:0] SF_LEFT   = 2'h1;
  localparam logic [1:0] SF_RIGHT  = 2'h3;
  // =====================================================================
  // saturation values and special operands
  localparam logic [47:0] SINT_MAX   = 48'h0000_7fff_ffff;
  localparam logic [47:0] SINT_MIN   = 48'hffff_8000_0000;
  localparam logic [47:0] FRAC_MAX   = 48'h007f_ffff_ffff;
  localparam logic [47:0] FRAC_MIN   = 48'hff80_0000_0000;
  localparam logic [47:0] UINT_MAX   = 48'hffff_ffff_ffff;
  localparam logic [31:0] FRAC_M1    = 32'h8000_0000;
  localparam logic [23:0] ROUND_HALF = 24'h80_0000;
  localparam int          STALL_CYCLES = 3;
endpackage : mac_pkg
`default_nettype wire

// *** verilog/mac_unit.sv ***
// four-stage multiply-accumulate unit with AHB-Lite register access
//
// Design decisions made here: the address map and the AHB-Lite register port.
`default_nettype none
module mac_unit
(
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // instruction issue from the core
  input  wire logic                 issue_valid,
  input  wire logic [1:0]           issue_op,
  input  wire logic                 issue_long,
  input  wire logic                 x_half_select,
  input  wire logic                 y_half_select,
  input  wire logic [1:0]           scale_factor,
  input  wire logic [1:0]           target_accumulator,
  input  wire logic [1:0]           source_accumulator,
  input  wire logic [31:0]          rx,
  input  wire logic [31:0]          ry,
  // accumulator copy into a core register
  input  wire logic                 acc_read_req,
  input  wire logic [1:0]           acc_read_sel,
  output logic                      acc_read_stall,
  output logic                      acc_read_valid,
  output logic [31:0]               acc_read_data
);
  import mac_pkg::*;

  // =====================================================================
  // architectural state
  logic [47:0] acc_q [4];                  // [RULE1]
  logic [3:0]  sticky_q;
  logic [3:0]  cfg_q;
  logic [3:0]  flags_q;

  function automatic logic is_frac(input logic [1:0] m);
    is_frac = m[0];                        // [RULE5]
  endfunction : is_frac

  // =====================================================================
  // stage 1: operand select, overlaps core's last operand stage
  logic [31:0] x1;
  logic [31:0] y1;
  logic [15:0] xh;
  logic [15:0] yh;
  logic [1:0]  mode1;
  assign mode1 = cfg_q[6-4:5-4];
  always_comb
  begin
    xh = x_half_select ? rx[31:16] : rx[15:0];  // [RULE11]
    yh = y_half_select ? ry[31:16] : ry[15:0];
    if (issue_long || issue_op == OP_LOAD)
    begin
      x1 = rx;
      y1 = ry;
    end
    else if (is_frac(mode1))
    begin
      x1 = {xh, 16'h0000};                 // [RULE12]
      y1 = {yh, 16'h0000};
    end
    else if (mode1 == MODE_UINT)
    begin
      x1 = {16'h0000, xh};
      y1 = {16'h0000, yh};
    end
    else
    begin
      x1 = {{16{xh[15]}}, xh};             // [RULE11]
      y1 = {{16{yh[15]}}, yh};
    end
  end

  // =====================================================================
  // pipeline valid, control and hazard tracking
  logic       v2_q, v3_q, v4_q;
  logic [1:0] op2_q, op3_q, op4_q;
  logic [1:0] a2_q, a3_q, a4_q;
  logic [1:0] src2_q, src3_q, src4_q;
  logic [1:0] m2_q, m3_q, m4_q;
  logic [1:0] sf2_q, sf3_q;
  logic       l2_q, l3_q, rnd2_q, rnd3_q;
  logic       issue_go;
  assign issue_go = issue_valid;           // never stalled [RULE4]

  // control moves one stage per cycle, no stalls [RULE1] [RULE2]
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      v2_q <= 1'b0; v3_q <= 1'b0; v4_q <= 1'b0;
      op2_q <= 2'h0; op3_q <= 2'h0; op4_q <= 2'h0;
      a2_q <= 2'h0; a3_q <= 2'h0; a4_q <= 2'h0;
      src2_q <= 2'h0; src3_q <= 2'h0; src4_q <= 2'h0;
      m2_q <= 2'h0; m3_q <= 2'h0; m4_q <= 2'h0;
      sf2_q <= 2'h0; sf3_q <= 2'h0;
      l2_q <= 1'b0; l3_q <= 1'b0; rnd2_q <= 1'b0; rnd3_q <= 1'b0;
    end
    else
    begin
      v2_q <= issue_go; v3_q <= v2_q; v4_q <= v3_q;
      op2_q <= issue_op; op3_q <= op2_q; op4_q <= op3_q;
      a2_q <= target_accumulator; a3_q <= a2_q; a4_q <= a3_q;
      src2_q <= source_accumulator; src3_q <= src2_q; src4_q <= src3_q;
      m2_q <= mode1; m3_q <= m2_q; m4_q <= m3_q;
      sf2_q <= scale_factor; sf3_q <= sf2_q;
      l2_q <= issue_long; l3_q <= l2_q;
      rnd2_q <= cfg_q[ROUND_BIT-4]; rnd3_q <= rnd2_q;
    end
  end

  // copy waits while an older write to that accumulator is in flight [RULE3]
  assign acc_read_stall = acc_read_req &&
    ((v2_q && a2_q == acc_read_sel) || (v3_q && a3_q == acc_read_sel) ||
     (v4_q && a4_q == acc_read_sel));

  // =====================================================================
  // stage 2: full 32x32 multiply
  logic [31:0] x2_q, y2_q;
  logic [63:0] prod3_q;
  logic [31:0] ld3_q;
  logic        m1sq3_q;
  logic [63:0] xe, ye;
  always_comb
  begin
    xe = {(m2_q == MODE_UINT) ? 32'h0 : {32{x2_q[31]}}, x2_q};
    ye = {(m2_q == MODE_UINT) ? 32'h0 : {32{y2_q[31]}}, y2_q};
  end

  // operand and product registers [RULE1]
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      x2_q <= 32'h0; y2_q <= 32'h0;
      prod3_q <= 64'h0; ld3_q <= 32'h0; m1sq3_q <= 1'b0;
    end
    else
    begin
      x2_q <= x1;
      y2_q <= y1;
      prod3_q <= xe * ye;
      ld3_q <= x2_q;
      m1sq3_q <= (x2_q == FRAC_M1) && (y2_q == FRAC_M1);  // [RULE6] [RULE23]
    end
  end

  // =====================================================================
  // stage 3: overflow check, extend, round, scale
  logic [63:0] pf;
  logic [47:0] p3;
  logic        povf3;
  logic [47:0] psat3;
  logic        fill3;
  always_comb
  begin
    pf = prod3_q << 1;                      // [RULE13]
    povf3 = 1'b0;
    psat3 = 48'h0;
    fill3 = 1'b0;
    if (op3_q == OP_LOAD)
      p3 = {{16{ld3_q[31]}}, ld3_q};
    else if (is_frac(m3_q))
    begin
      // convergent rounding of the shifted product [RULE22]
      if (rnd3_q && (pf[23:0] > ROUND_HALF ||
                     (pf[23:0] == ROUND_HALF && pf[24])))
        pf[63:24] = pf[63:24] + 40'h1;
      p3 = {m1sq3_q ? 8'h00 : {8{pf[63]}}, pf[63:24]};  // [RULE23]
      // no scaling in fractional mode [RULE19]
    end
    else
    begin
      if (m3_q == MODE_UINT)
      begin
        povf3 = prod3_q[63:40] != 24'h0;
        psat3 = (op3_q == OP_MULTIPLY_SUBTRACT) ? 48'h0 : UINT_MAX;
        p3 = {8'h00, prod3_q[39:0]};
      end
      else
      begin
        povf3 = (prod3_q[63:39] != 25'h0) && (prod3_q[63:39] != {25{1'b1}});  // [RULE14] [RULE8]
        if (op3_q == OP_MULTIPLY_SUBTRACT)
          psat3 = prod3_q[63] ? SINT_MAX : SINT_MIN;  // [RULE14]
        else
          psat3 = prod3_q[63] ? SINT_MIN : SINT_MAX;
        p3 = {{8{prod3_q[39]}}, prod3_q[39:0]};  // [RULE16]
        fill3 = prod3_q[39] && (prod3_q[39:0] != 40'h0) && !(l3_q && povf3);  // [RULE18]
      end
      // scale factor [RULE17]
      if (sf3_q == SF_LEFT)
        p3[40:0] = {p3[39:0], 1'b0};
      else if (sf3_q == SF_RIGHT)
        p3[39:0] = {fill3, p3[39:1]};      // [RULE18]
    end
  end

  logic [47:0] p4_q, psat4_q;
  logic        povf4_q;
  // scaled product register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      p4_q <= 48'h0; psat4_q <= 48'h0; povf4_q <= 1'b0;
    end
    else
    begin
      p4_q <= p3;
      psat4_q <= psat3;
      povf4_q <= povf3;
    end
  end

  // =====================================================================
  // stage 4: combine with the accumulator
  logic [47:0] acc_old;
  logic [48:0] sum;
  logic [47:0] res;
  logic        aovf;
  logic        skip;
  logic        sat;
  logic        new_sticky;
  logic        wr_acc;
  logic [3:0]  flags_d;
  assign acc_old = acc_q[a4_q];
  assign sat = cfg_q[SAT_BIT-4];
  assign skip = sat && sticky_q[a4_q];     // [RULE10]
  assign wr_acc = v4_q && !(skip && (op4_q == OP_MAC || op4_q == OP_MULTIPLY_SUBTRACT));

  always_comb
  begin
    if (op4_q == OP_MULTIPLY_SUBTRACT)
      sum = {1'b0, acc_old} - {1'b0, p4_q};  // [RULE20]
    else
      sum = {1'b0, acc_old} + {1'b0, p4_q};
    if (m4_q == MODE_UINT)
      aovf = sum[48];
    else if (op4_q == OP_MULTIPLY_SUBTRACT)
      aovf = (acc_old[47] != p4_q[47]) && (sum[47] != acc_old[47]);
    else
      aovf = (acc_old[47] == p4_q[47]) && (sum[47] != acc_old[47]);
    res = sum[47:0];
    new_sticky = povf4_q || aovf;          // [RULE8]
    if (op4_q == OP_LOAD)
    begin
      res = p4_q;
      new_sticky = 1'b0;
    end
    else if (op4_q == OP_COPY)
    begin
      res = acc_q[src4_q];
      new_sticky = sticky_q[src4_q];
    end
    else if (sat && povf4_q)
      res = psat4_q;                       // [RULE14]
    else if (sat && aovf)
    begin
      if (m4_q == MODE_UINT)
        res = psat4_q;
      else if (is_frac(m4_q))
        res = sum[47] ? FRAC_MAX : FRAC_MIN;
      else
        res = sum[47] ? SINT_MAX : SINT_MIN;  // [RULE15]
    end
  end

  // condition flags from the final accumulator value
  logic [47:0] fin;
  logic        ev;
  always_comb
  begin
    fin = wr_acc ? res : acc_old;
    if (is_frac(m4_q))
      ev = !((fin[47:39] == 9'h0) || (fin[47:39] == 9'h1ff));
    else if (m4_q == MODE_UINT)
      ev = fin[47:32] != 16'h0;
    else
      ev = !((fin[47:31] == 17'h0) || (fin[47:31] == 17'h1ffff));  // [RULE21]
    flags_d[FLAG_N] = fin[47];             // [RULE7]
    flags_d[FLAG_Z] = fin == 48'h0;        // [RULE7]
    flags_d[FLAG_V] = wr_acc ? new_sticky : sticky_q[a4_q];  // [RULE9]
    flags_d[FLAG_EV] = ev;
  end

  // accumulator write at the end of the fourth stage [RULE1]
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      for (int i = 0; i < 4; i++)
        acc_q[i] <= 48'h0;
    else if (wr_acc)
      acc_q[a4_q] <= res;                  // [RULE10]
  end

  // =====================================================================
  // AHB-Lite slave, zero wait states, always OKAY
  logic       dph_wr_q;
  logic [7:0] dph_adr_q;
  logic       take;
  logic [31:0] rd_d;
  assign take = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // read data decode, unmapped reads zero
  always_comb
  begin
    if (haddr[7:0] == STATUS_OFS)
      rd_d = {20'h0, sticky_q, cfg_q, flags_q};  // [RULE24]
    else if (haddr[7:4] == ACC_LO_OFS[7:4] && haddr[1:0] == 2'h0)
      rd_d = acc_q[haddr[3:2]][31:0];
    else if (haddr[7:4] == ACC_HI_OFS[7:4] && haddr[1:0] == 2'h0)
      rd_d = {16'h0, acc_q[haddr[3:2]][47:32]};
    else
      rd_d = 32'h0;
    if (haddr[31:8] != 24'h0)
      rd_d = 32'h0;
  end

  // address phase capture and read data register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_q <= 1'b0;
      dph_adr_q <= 8'h0;
      hrdata <= 32'h0;
    end
    else
    begin
      dph_wr_q <= take && hwrite && haddr[31:8] == 24'h0 && hsize == 3'h2;
      dph_adr_q <= haddr[7:0];
      if (take && !hwrite)
        hrdata <= rd_d;
    end
  end

  logic sw_wr;
  assign sw_wr = dph_wr_q && dph_adr_q == STATUS_OFS;

  // status register: hardware update wins over a software write [RULE24]
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sticky_q <= STATUS_RESET[11:8];
      cfg_q <= STATUS_RESET[7:4];
      flags_q <= STATUS_RESET[3:0];
    end
    else
    begin
      if (sw_wr)
      begin
        sticky_q <= hwdata[11:8];
        cfg_q <= hwdata[7:4];
        flags_q <= hwdata[3:0];
      end
      if (v4_q)
      begin
        if (wr_acc)
          sticky_q[a4_q] <= new_sticky;    // [RULE8] [RULE10]
        flags_q <= flags_d;                // [RULE9]
      end
    end
  end

  // copy of the accumulator into a core register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_read_valid <= 1'b0;
      acc_read_data <= 32'h0;
    end
    else
    begin
      acc_read_valid <= acc_read_req && !acc_read_stall;
      if (acc_read_req && !acc_read_stall)
        acc_read_data <= acc_q[acc_read_sel][31:0];
    end
  end

  // =====================================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [1:0] past_a4;
  logic       past_v4;
  logic       past_skip;
  logic [47:0] past_old;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      past_a4 <= 2'h0; past_v4 <= 1'b0; past_skip <= 1'b0; past_old <= 48'h0;
    end
    else
    begin
      past_a4 <= a4_q; past_v4 <= v4_q;
      past_skip <= v4_q && skip && (op4_q == OP_MAC || op4_q == OP_MULTIPLY_SUBTRACT);
      past_old <= acc_old;
    end
  end

  sequence mac_issued;
    issue_valid && (issue_op == OP_MAC || issue_op == OP_MULTIPLY_SUBTRACT);
  endsequence
  sequence copy_waits;
    acc_read_stall [*3] ##1 !acc_read_stall;
  endsequence

  a_copy_stall_three: assert property (  // [RULE3]
    mac_issued ##1 (acc_read_req && acc_read_sel == a2_q && !issue_valid)
      |-> copy_waits)
    else $error("copy stall not three cycles");
  a_stall_window: assert property (  // [RULE3]
    (issue_valid && !v2_q && !v3_q && !v4_q) ##1
      (acc_read_req && acc_read_sel == a2_q) |-> acc_read_stall)
    else $error("copy not held behind update");
  a_pipe_depth: assert property (  // [RULE1]
    issue_valid |-> ##3 v4_q)
    else $error("pipeline depth not four");
  a_neg_flag: assert property (  // [RULE7]
    past_v4 |-> flags_q[FLAG_N] == acc_q[past_a4][47])
    else $error("negative flag mismatch");
  a_zero_flag: assert property (  // [RULE7]
    past_v4 |-> flags_q[FLAG_Z] == (acc_q[past_a4] == 48'h0))
    else $error("zero flag mismatch");
  a_v_is_sticky: assert property (  // [RULE9]
    past_v4 |-> flags_q[FLAG_V] == sticky_q[past_a4])
    else $error("overflow flag not sticky copy");
  a_sat_hold: assert property (  // [RULE10]
    past_skip |-> acc_q[past_a4] == past_old && sticky_q[past_a4])
    else $error("saturated accumulator changed");
  a_prod_ovf_sticky: assert property (  // [RULE8]
    (v3_q && povf3 && (op3_q == OP_MAC || op3_q == OP_MULTIPLY_SUBTRACT) && !(sat && sticky_q[a3_q])
      && !(sw_wr)) ##1 (!sw_wr && !(v4_q && skip)) |=> sticky_q[$past(a4_q)])
    else $error("product overflow not sticky");
  a_no_issue_stall: assert property (  // [RULE4]
    issue_valid |=> v2_q && op2_q == $past(issue_op) && a2_q == $past(target_accumulator))
    else $error("issued instruction not taken");
endmodule : mac_unit
`default_nettype wire

// *** verilog/_unused_placeholder_check.sv ***
// empty compilation unit kept intentionally minimal
`default_nettype none
`default_nettype wire

// *** testbench/core_model.sv ***
// core-side issue and accumulator-copy model facing the multiply-accumulate unit
`default_nettype none
module core_model
(
  // clock
  input  wire logic        hclk,
  // instruction issue
  output logic             issue_valid,
  output logic [1:0]       issue_op,
  output logic             issue_long,
  output logic             x_half_select,
  output logic             y_half_select,
  output logic [1:0]       scale_factor,
  output logic [1:0]       target_accumulator,
  output logic [1:0]       source_accumulator,
  output logic [31:0]      rx,
  output logic [31:0]      ry,
  // accumulator copy into a core register
  output logic             acc_read_req,
  output logic [1:0]       acc_read_sel,
  input  wire logic        acc_read_stall,
  input  wire logic        acc_read_valid,
  input  wire logic [31:0] acc_read_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // =====================================================================
  // quiet pipeline at time zero
  initial
  begin
    {issue_valid, issue_op, issue_long, x_half_select, y_half_select} = '0;
    {scale_factor, target_accumulator, source_accumulator, rx, ry} = '0;
    {acc_read_req, acc_read_sel} = '0;
  end
  // =====================================================================
  // one instruction per cycle from the last operand stage
  task issue(input logic [1:0] op, input logic lng, xh, yh, input logic [1:0] sf, ta, sa,
             input logic [31:0] a, b);
    @(posedge hclk);
    issue_valid <= 1'b1;
    {issue_op, issue_long, x_half_select, y_half_select} <= {op, lng, xh, yh};
    {scale_factor, target_accumulator, source_accumulator} <= {sf, ta, sa};
    {rx, ry} <= {a, b};
  endtask : issue
  // copy an accumulator; returns the data and the cycles spent stalled
  task rd(input logic [1:0] sel, output logic [31:0] d, output int n);
    n = 0;
    @(posedge hclk);
    issue_valid <= 1'b0;
    {rx, ry} <= ~{rx, ry}; // released operands do not keep their value
    acc_read_req <= 1'b1;
    acc_read_sel <= sel;
    @(negedge hclk);
    while (acc_read_stall === 1'b1 && n < 20)
    begin
      n++;
      @(negedge hclk);
    end
    @(posedge hclk);
    acc_read_req <= 1'b0;
    @(negedge hclk);
    d = (acc_read_valid === 1'b1) ? acc_read_data : 32'hxxxx_xxxx;
  endtask : rd
endmodule : core_model
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the multiply-accumulate unit
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import mac_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, a, b, d, acc_read_data, rx, ry;
  logic [1:0]  htrans, issue_op, scale_factor, target_accumulator, source_accumulator;
  logic [1:0]  acc_read_sel, sf, ta, last;
  logic [2:0]  hsize;
  logic        issue_valid, issue_long, x_half_select, y_half_select, xh, yh;
  logic        acc_read_req, acc_read_stall, acc_read_valid;
  logic [47:0] acc_x [4];
  int          fails, n_checks, cyc, s;
  // =====================================================================
  // design, core model and clock
  mac_unit dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .issue_valid, .issue_op, .issue_long,
    .x_half_select, .y_half_select, .scale_factor, .target_accumulator, .source_accumulator,
    .rx, .ry, .acc_read_req, .acc_read_sel, .acc_read_stall, .acc_read_valid, .acc_read_data);
  core_model core (.hclk, .issue_valid, .issue_op, .issue_long, .x_half_select,
    .y_half_select, .scale_factor, .target_accumulator, .source_accumulator, .rx, .ry,
    .acc_read_req, .acc_read_sel, .acc_read_stall, .acc_read_valid, .acc_read_data);
  always #5 hclk = ~hclk;
  // =====================================================================
  // expectations
  function automatic logic [47:0] sint_step(logic [47:0] acc, logic [31:0] x, y,
    logic xh, yh, logic [1:0] sf, logic sub);
    logic [31:0] ox, oy;
    logic [63:0] p;
    logic [47:0] q;
    ox = xh ? {{16{x[31]}}, x[31:16]} : {{16{x[15]}}, x[15:0]};
    oy = yh ? {{16{y[31]}}, y[31:16]} : {{16{y[15]}}, y[15:0]};
    p = $signed(ox) * $signed(oy);
    q = {{8{p[39]}}, p[39:0]};
    if (sf == SF_LEFT) q[40:0] = {q[39:0], 1'b0};
    if (sf == SF_RIGHT) q[39:0] = {(p == 64'h0) ? 1'b0 : q[39], q[39:1]};
    return sub ? acc - q : acc + q;
  endfunction : sint_step
  function automatic logic [3:0] flg(logic [47:0] v);
    return {v[47], v == 48'h0, 1'b0, ~(&v[47:31] | ~|v[47:31])};
  endfunction : flg
  // =====================================================================
  // comparison, verdict and hang guard
  task chk(input logic [47:0] got, exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : chk
  task results;
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end
  // =====================================================================
  // register bus master
  task ahb_wait;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && cyc < 20000) @(posedge hclk);
  endtask : ahb_wait
  task ahb_xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge hclk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, ad, 2'h2, wr};
    ahb_wait();
    htrans <= 2'h0;
    hwdata <= wd;
    ahb_wait();
    d = hrdata;
  endtask : ahb_xfer
  // =====================================================================
  // main sequence
  initial
  begin
    {hclk, hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    {fails, n_checks, cyc} = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(32'h17ac7120));
    ahb_xfer(1'b0, STATUS_OFS, 32'h0);
    chk(d[11:0], STATUS_RESET, "status reset");
    ahb_xfer(1'b0, 8'h30, 32'h0);
    chk(d, 0, "unmapped read");
    chk(hresp, 1'b0, "response");
    // random loads, then back-to-back signed integer accumulate and subtract
    for (int i = 0; i < 4; i++)
    begin
      a = $urandom;
      core.issue(OP_LOAD, 1'b1, 1'b0, 1'b0, 2'h0, 2'(i), 2'h0, a, 32'h0);
      acc_x[i] = {{16{a[31]}}, a};
    end
    for (int n = 0; n < 24; n++)
    begin
      d = $urandom;
      {xh, yh, sf, ta} = d[5:0];
      a = $urandom;
      b = $urandom;
      core.issue({1'b0, d[6]}, 1'b0, xh, yh, sf, ta, 2'h0, a, b);
      acc_x[ta] = sint_step(acc_x[ta], a, b, xh, yh, sf, d[6]);
      last = ta;
    end
    core.issue(OP_COPY, 1'b0, 1'b0, 1'b0, 2'h0, 2'h3, last, 32'h0, 32'h0);
    acc_x[3] = acc_x[last];
    core.rd(2'h3, d, s);
    chk(d, acc_x[3][31:0], "copy after accumulate");
    chk(48'(s), 48'(STALL_CYCLES), "stall length");
    ahb_xfer(1'b0, STATUS_OFS, 32'h0);
    chk(d[11:0], {8'h00, flg(acc_x[3])}, "flags");
    ahb_xfer(1'b1, ACC_LO_OFS, 32'hffff_ffff);
    for (int i = 0; i < 4; i++)
    begin
      ahb_xfer(1'b0, ACC_LO_OFS + 8'(4 * i), 32'h0);
      chk(d, acc_x[i][31:0], "acc low window");
      ahb_xfer(1'b0, ACC_HI_OFS + 8'(4 * i), 32'h0);
      chk(d[15:0], acc_x[i][47:32], "acc high window");
    end
    // zero product shifted right leaves a zero accumulator
    core.issue(OP_LOAD, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 32'h0, 32'h0);
    core.issue(OP_MULTIPLY_SUBTRACT, 1'b0, 1'b0, 1'b0, SF_RIGHT, 2'h0, 2'h0, 32'h0, 32'h1234);
    core.rd(2'h0, d, s);
    chk(d, 0, "zero product");
    ahb_xfer(1'b0, STATUS_OFS, 32'h0);
    chk(d[11:0], 12'h004, "zero flag");
    // saturation on a long product overflow, then a frozen accumulator
    ahb_xfer(1'b1, STATUS_OFS, 32'h080);
    core.issue(OP_LOAD, 1'b1, 1'b0, 1'b0, 2'h0, 2'h2, 2'h0, 32'h0, 32'h0);
    core.issue(OP_MAC, 1'b1, 1'b0, 1'b0, 2'h0, 2'h2, 2'h0, 32'h7fff_ffff, 32'h7fff_ffff);
    core.issue(OP_MULTIPLY_SUBTRACT, 1'b0, 1'b0, 1'b0, 2'h0, 2'h2, 2'h0, 32'h1, 32'h1);
    core.rd(2'h2, d, s);
    chk(d, SINT_MAX[31:0], "saturated acc");
    ahb_xfer(1'b0, STATUS_OFS, 32'h0);
    chk(d[11:0], 12'h482, "sticky and overflow");
    // fractional word and minus-one-squared, scale ignored
    ahb_xfer(1'b1, STATUS_OFS, 32'h020);
    core.issue(OP_LOAD, 1'b1, 1'b0, 1'b0, 2'h0, 2'h1, 2'h0, 32'h0, 32'h0);
    core.issue(OP_MAC, 1'b0, 1'b1, 1'b0, SF_RIGHT, 2'h1, 2'h0, 32'h4000_0000, 32'h4000);
    core.issue(OP_MAC, 1'b1, 1'b0, 1'b0, SF_LEFT, 2'h1, 2'h0, FRAC_M1, FRAC_M1);
    core.rd(2'h1, d, s);
    chk(d, 0, "fractional low");
    ahb_xfer(1'b0, ACC_HI_OFS + 8'h4, 32'h0);
    chk(d[15:0], 16'h00a0, "fractional high");
    // convergent rounding: a tie on an even bit stays, above half rounds up
    ahb_xfer(1'b1, STATUS_OFS, 32'h070);
    core.issue(OP_LOAD, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 32'h0, 32'h0);
    core.issue(OP_MAC, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 32'h1, 32'h0040_0000);
    core.issue(OP_MAC, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 32'h1, 32'h0040_0001);
    core.rd(2'h0, d, s);
    chk(d, 1, "rounding");
    // unsigned word operands are zero-extended
    ahb_xfer(1'b1, STATUS_OFS, 32'h040);
    core.issue(OP_LOAD, 1'b1, 1'b0, 1'b0, 2'h0, 2'h3, 2'h0, 32'h0, 32'h0);
    core.issue(OP_MAC, 1'b0, 1'b0, 1'b0, 2'h0, 2'h3, 2'h0, 32'hffff, 32'hffff);
    core.rd(2'h3, d, s);
    chk(d, 32'hfffe_0001, "unsigned word");
    results();
  end
endmodule : testbench
`default_nettype wire
